// [rtl/bls_host.sv]
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - host holds bus width select high to use the sixteen-bit port
// - low byte select low with high enable high moves only lanes 7:0
// - high enable low with low byte select high moves only lanes 15:8
// - word-only host drives both selects low on every sixteen-bit cycle
// - narrow mode: width select low, data only on lanes 7:0
module bls_host #(
    parameter bit NO_BYTE_LANES = 1'b0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wide_mode,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [12:0] req_addr,
    input wire logic [1:0] req_be,
    input wire logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic dev_bus_width_16,
    output logic [11:0] dev_addr_upper,
    output logic host_low_byte_enable_n,
    output logic high_byte_enable_n,
    output logic dev_ce_n,
    output logic dev_oe_n,
    output logic dev_we_n,
    input wire logic [15:0] dev_data_in,
    output logic [15:0] dev_data_out,
    output logic [1:0] dev_data_oe_n
);

    localparam logic [4:0] SETUP_LD = 5'(bls_pkg::SETUP_CYC - 1);
    localparam logic [4:0] WRITE_LD = 5'(bls_pkg::WRITE_CYC - 1);
    localparam logic [4:0] READ_LD = 5'(bls_pkg::READ_CYC - 1);
    localparam logic [4:0] RECOVER_LD = 5'(bls_pkg::RECOVER_CYC - 1);
    // strobe cycles left after the eight checked ones, plus the answer cycle
    localparam int RD_WAIT = bls_pkg::READ_CYC - 7;
    localparam int WR_WAIT = bls_pkg::WRITE_CYC;

    // ****************************************
    // pin synchroniser
    // ****************************************
    logic [15:0] din_meta_reg;
    logic [15:0] din_sync_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            din_meta_reg <= bls_pkg::RST_DATA;
            din_sync_reg <= bls_pkg::RST_DATA;
        end
        else
        begin
            din_meta_reg <= dev_data_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // ****************************************
    // lane decode of the incoming request
    // ****************************************
    logic map_low_sel_n;
    logic map_high_en_n;
    logic [1:0] map_lane_en;
    logic map_noop;

    bls_lane_map #(
        .NO_BYTE_LANES(NO_BYTE_LANES)
    ) u_lane_map (
        .wide(wide_mode),
        .be(req_be),
        .addr0(req_addr[0]),
        .low_sel_n(map_low_sel_n),
        .high_en_n(map_high_en_n),
        .lane_en(map_lane_en),
        .noop(map_noop)
    );

    // ****************************************
    // cycle sequencer
    // ****************************************
    bls_pkg::bls_state_t state_reg, state_next;
    logic [4:0] cnt_reg, cnt_next;
    logic write_reg, write_next;
    logic [1:0] lane_reg, lane_next;
    logic width_reg, width_next;
    logic [11:0] addr_reg, addr_next;
    logic low_sel_reg, low_sel_next;
    logic high_en_reg, high_en_next;
    logic ce_reg, ce_next;
    logic oe_reg, oe_next;
    logic we_reg, we_next;
    logic [15:0] dout_reg, dout_next;
    logic [1:0] doe_reg, doe_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [15:0] rdata_reg, rdata_next;

    assign req_ready = (state_reg == bls_pkg::BLS_IDLE);

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        write_next = write_reg;
        lane_next = lane_reg;
        width_next = width_reg;
        addr_next = addr_reg;
        low_sel_next = low_sel_reg;
        high_en_next = high_en_reg;
        ce_next = ce_reg;
        oe_next = oe_reg;
        we_next = we_reg;
        dout_next = dout_reg;
        doe_next = doe_reg;
        rsp_valid_next = 1'b0;
        rdata_next = rdata_reg;
        unique case (state_reg)
            bls_pkg::BLS_IDLE:
            begin
                if (req_valid)
                begin
                    if (map_noop)
                    begin
                        // nothing would move, so no strobe is spent
                        rsp_valid_next = 1'b1;
                        rdata_next = 16'h0000;
                    end
                    else
                    begin
                        state_next = bls_pkg::BLS_SETUP;
                        cnt_next = SETUP_LD;
                        write_next = req_write;
                        lane_next = map_lane_en;
                        width_next = wide_mode;
                        addr_next = req_addr[12:1];
                        low_sel_next = map_low_sel_n;
                        high_en_next = map_high_en_n;
                        ce_next = 1'b0;
                        // low lane carries the low byte in both modes
                        dout_next = wide_mode ? req_wdata : {8'h00, req_wdata[7:0]};
                        doe_next = req_write ? ~map_lane_en : bls_pkg::RST_LANE_OE_N;
                    end
                end
            end
            bls_pkg::BLS_SETUP:
            begin
                cnt_next = cnt_reg - 5'h01;
                if (cnt_reg == 5'h00)
                begin
                    state_next = bls_pkg::BLS_STROBE;
                    cnt_next = write_reg ? WRITE_LD : READ_LD;
                    we_next = ~write_reg;
                    oe_next = write_reg;
                end
            end
            bls_pkg::BLS_STROBE:
            begin
                cnt_next = cnt_reg - 5'h01;
                if (cnt_reg == 5'h00)
                begin
                    state_next = bls_pkg::BLS_RECOVER;
                    cnt_next = RECOVER_LD;
                    we_next = 1'b1;
                    oe_next = 1'b1;
                    rsp_valid_next = 1'b1;
                    // unused lanes read as zero
                    rdata_next = {lane_reg[1] ? din_sync_reg[15:8] : 8'h00,
                        lane_reg[0] ? din_sync_reg[7:0] : 8'h00};
                end
            end
            bls_pkg::BLS_RECOVER:
            begin
                // data and select held one cycle past the strobe edge
                ce_next = 1'b1;
                doe_next = bls_pkg::RST_LANE_OE_N;
                cnt_next = cnt_reg - 5'h01;
                if (cnt_reg == 5'h00)
                begin
                    state_next = bls_pkg::BLS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= bls_pkg::BLS_IDLE;
            cnt_reg <= 5'h00;
            write_reg <= 1'b0;
            lane_reg <= 2'h0;
            width_reg <= 1'b0;
            addr_reg <= 12'h000;
            low_sel_reg <= 1'b1;
            high_en_reg <= 1'b1;
            ce_reg <= bls_pkg::RST_STROBE_N;
            oe_reg <= bls_pkg::RST_STROBE_N;
            we_reg <= bls_pkg::RST_STROBE_N;
            dout_reg <= bls_pkg::RST_DATA;
            doe_reg <= bls_pkg::RST_LANE_OE_N;
            rsp_valid_reg <= 1'b0;
            rdata_reg <= bls_pkg::RST_DATA;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            write_reg <= write_next;
            lane_reg <= lane_next;
            width_reg <= width_next;
            addr_reg <= addr_next;
            low_sel_reg <= low_sel_next;
            high_en_reg <= high_en_next;
            ce_reg <= ce_next;
            oe_reg <= oe_next;
            we_reg <= we_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
            rsp_valid_reg <= rsp_valid_next;
            rdata_reg <= rdata_next;
        end
    end

    assign dev_bus_width_16 = width_reg;
    assign dev_addr_upper = addr_reg;
    assign host_low_byte_enable_n = low_sel_reg;
    assign high_byte_enable_n = high_en_reg;
    assign dev_ce_n = ce_reg;
    assign dev_oe_n = oe_reg;
    assign dev_we_n = we_reg;
    assign dev_data_out = dout_reg;
    assign dev_data_oe_n = doe_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rdata_reg;

    // ****************************************
    // checks
    // ****************************************
    property p_width_stable;
        @(posedge clk) disable iff (sys_rst)
        (!dev_ce_n && $past(!dev_ce_n)) |-> $stable(dev_bus_width_16);
    endproperty
    a_width_stable: assert property (p_width_stable)
        else $error("width select moved inside a cycle");

    property p_low_lane;
        @(posedge clk) disable iff (sys_rst)
        (!dev_we_n && dev_bus_width_16) |-> (dev_data_oe_n[0] == host_low_byte_enable_n);
    endproperty
    a_low_lane: assert property (p_low_lane)
        else $error("low lane drive disagrees with low byte select");

    property p_high_lane;
        @(posedge clk) disable iff (sys_rst)
        (!dev_we_n && dev_bus_width_16) |-> (dev_data_oe_n[1] == high_byte_enable_n);
    endproperty
    a_high_lane: assert property (p_high_lane)
        else $error("high lane drive disagrees with high byte enable");

    property p_word_only;
        @(posedge clk) disable iff (sys_rst)
        (NO_BYTE_LANES && !dev_ce_n && dev_bus_width_16) |-> (!host_low_byte_enable_n && !high_byte_enable_n);
    endproperty
    a_word_only: assert property (p_word_only)
        else $error("word-only host issued a byte select");

    property p_narrow;
        @(posedge clk) disable iff (sys_rst)
        (!dev_ce_n && !dev_bus_width_16) |-> (dev_data_oe_n[1] && high_byte_enable_n);
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("upper lane used in narrow mode");

    property p_noop_quiet;
        @(posedge clk) disable iff (sys_rst)
        (req_valid && req_ready && map_noop) |=> (rsp_valid && dev_ce_n && dev_oe_n && dev_we_n);
    endproperty
    a_noop_quiet: assert property (p_noop_quiet)
        else $error("no-operation request produced a strobe");

    property p_read_time;
        @(posedge clk) disable iff (sys_rst)
        $fell(dev_oe_n) |-> (!dev_oe_n && !rsp_valid) [*8] ##[RD_WAIT:RD_WAIT] (rsp_valid && dev_oe_n);
    endproperty
    a_read_time: assert property (p_read_time)
        else $error("read strobe length wrong");

    property p_write_time;
        @(posedge clk) disable iff (sys_rst)
        $fell(dev_we_n) |-> ##[WR_WAIT:WR_WAIT] (dev_we_n && rsp_valid && !dev_ce_n);
    endproperty
    a_write_time: assert property (p_write_time)
        else $error("write strobe length wrong");

endmodule

`default_nettype wire

// [rtl/bls_lane_map.sv]
`timescale 1ns/1ps
`default_nettype none

module bls_lane_map #(
    parameter bit NO_BYTE_LANES = 1'b0
) (
    input wire logic wide,
    input wire logic [1:0] be,
    input wire logic addr0,
    output logic low_sel_n,
    output logic high_en_n,
    output logic [1:0] lane_en,
    output logic noop
);

    logic [1:0] eff_be;

    always_comb
    begin
        // word-only hosts tie both selects low in wide mode
        eff_be = NO_BYTE_LANES ? 2'h3 : be;
        if (wide)
        begin
            low_sel_n = ~eff_be[0];
            high_en_n = ~eff_be[1];
            lane_en = eff_be;
            noop = (eff_be == 2'h0);
        end
        else
        begin
            // pin carries the real byte address bit here
            low_sel_n = addr0;
            high_en_n = 1'b1;
            lane_en = 2'h1;
            noop = 1'b0;
        end
    end

endmodule

`default_nettype wire

// [rtl/bls_pkg.sv]
package bls_pkg;

    // ****************************************
    // clock and timing, figures in ns
    // ****************************************
    localparam int CLK_NS = 5;
    localparam int T_ADDR_SETUP_NS = 10;
    localparam int T_CE_SETUP_NS = 6;
    localparam int T_WE_WIDTH_NS = 47;
    localparam int T_DATA_SETUP_NS = 51;
    localparam int T_READ_ACC_NS = 103;
    localparam int T_RECOVER_NS = 20;
    localparam int T_DATA_HIZ_NS = 25;
    localparam int SYNC_STAGES = 2;

    // least times round up
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max_int(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int SETUP_CYC = max_int(ceil_cyc(T_ADDR_SETUP_NS), ceil_cyc(T_CE_SETUP_NS));
    localparam int WRITE_CYC = max_int(ceil_cyc(T_WE_WIDTH_NS), ceil_cyc(T_DATA_SETUP_NS));
    // read strobe also covers the pin synchroniser delay
    localparam int READ_CYC = ceil_cyc(T_READ_ACC_NS) + SYNC_STAGES;
    localparam int RECOVER_CYC = max_int(ceil_cyc(T_RECOVER_NS), ceil_cyc(T_DATA_HIZ_NS));

    localparam int CNT_W = 5;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;

    // ****************************************
    // reset values of the pins
    // ****************************************
    localparam logic RST_STROBE_N = 1'b1;
    localparam logic [1:0] RST_LANE_OE_N = 2'h3;
    localparam logic [15:0] RST_DATA = 16'h0000;

    typedef enum logic [3:0] {
        BLS_IDLE = 4'h1,
        BLS_SETUP = 4'h2,
        BLS_STROBE = 4'h4,
        BLS_RECOVER = 4'h8
    } bls_state_t;

endpackage

// [testbench/bls_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none

module bls_dev_model (
    input wire logic clk,
    input wire logic dev_bus_width_16,
    input wire logic [11:0] dev_addr_upper,
    input wire logic host_low_byte_enable_n,
    input wire logic high_byte_enable_n,
    input wire logic dev_ce_n,
    input wire logic dev_oe_n,
    input wire logic dev_we_n,
    input wire logic [15:0] dev_data_out,
    input wire logic [1:0] dev_data_oe_n,
    output logic [15:0] dev_data_in
);
    logic [7:0] mem [8192];
    logic [15:0] last;
    logic we_q;
    logic rd;
    logic [1:0] drv;
    logic [12:0] lo_a;
    logic [12:0] hi_a;
    initial
    begin
        last = 16'h0000;
        we_q = 1'b1;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // narrow mode picks the byte with the low select pin
    assign lo_a = {dev_addr_upper, dev_bus_width_16 ? 1'b0 : host_low_byte_enable_n};
    assign hi_a = {dev_addr_upper, 1'b1};
    assign rd = !dev_ce_n && !dev_oe_n;
    assign drv[0] = rd && (!dev_bus_width_16 || !host_low_byte_enable_n);
    assign drv[1] = rd && dev_bus_width_16 && !high_byte_enable_n;
    // released lanes invert (upper lane reads FF in narrow mode), so a stale value never passes
    always_comb
    begin
        dev_data_in[7:0] = !dev_data_oe_n[0] ? dev_data_out[7:0] : drv[0] ? mem[lo_a] : ~last[7:0];
        dev_data_in[15:8] = !dev_data_oe_n[1] ? dev_data_out[15:8] : drv[1] ? mem[hi_a] :
            !dev_bus_width_16 ? 8'hFF : ~last[15:8];
    end
    always @(posedge clk)
    begin
        last <= dev_data_in;
        we_q <= dev_we_n;
        // write lands on the rising write strobe
        if (dev_we_n && !we_q && !dev_ce_n)
        begin
            if (!dev_bus_width_16 || !host_low_byte_enable_n) mem[lo_a] <= dev_data_in[7:0];
            if (dev_bus_width_16 && !high_byte_enable_n) mem[hi_a] <= dev_data_in[15:8];
        end
    end
endmodule

`default_nettype wire

// [testbench/bls_host_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module bls_host_tb_top;
    typedef struct packed {logic chk; logic [15:0] d;} bls_note_t;
    localparam int CYC_LIMIT = 8000;
    logic clk;
    logic sys_rst, wide_mode, req_valid, req_write, cur_wide, cur_noop;
    logic [12:0] req_addr, cur_a;
    logic [1:0] req_be, cur_be, dev_data_oe_n;
    logic [15:0] req_wdata, rsp_rdata, dev_data_in, dev_data_out;
    logic req_ready, rsp_valid, dev_bus_width_16, host_low_byte_enable_n, high_byte_enable_n;
    logic dev_ce_n, dev_oe_n, dev_we_n;
    logic wo_ce_n, wo_width, wo_lo_n, wo_hi_n;
    logic [11:0] dev_addr_upper;
    logic [7:0] shd [8192];
    bls_note_t notes [$];
    bls_note_t got;
    int n_errors, checks, cyc;

    bls_host bls_host_i (.clk(clk), .sys_rst(sys_rst), .wide_mode(wide_mode), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_be(req_be),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .dev_bus_width_16(dev_bus_width_16), .dev_addr_upper(dev_addr_upper),
        .host_low_byte_enable_n(host_low_byte_enable_n), .high_byte_enable_n(high_byte_enable_n),
        .dev_ce_n(dev_ce_n), .dev_oe_n(dev_oe_n), .dev_we_n(dev_we_n), .dev_data_in(dev_data_in),
        .dev_data_out(dev_data_out), .dev_data_oe_n(dev_data_oe_n));
    bls_dev_model bls_dev_model_i (.clk(clk), .dev_bus_width_16(dev_bus_width_16),
        .dev_addr_upper(dev_addr_upper), .host_low_byte_enable_n(host_low_byte_enable_n),
        .high_byte_enable_n(high_byte_enable_n), .dev_ce_n(dev_ce_n), .dev_oe_n(dev_oe_n),
        .dev_we_n(dev_we_n), .dev_data_out(dev_data_out), .dev_data_oe_n(dev_data_oe_n),
        .dev_data_in(dev_data_in));
    // word-only twin sees the same requests, only its selects are checked
    bls_host #(.NO_BYTE_LANES(1'b1)) bls_host_word_i (.clk(clk), .sys_rst(sys_rst), .wide_mode(wide_mode),
        .req_valid(req_valid), .req_ready(), .req_write(req_write), .req_addr(req_addr), .req_be(req_be),
        .req_wdata(req_wdata), .rsp_valid(), .rsp_rdata(), .dev_bus_width_16(wo_width), .dev_addr_upper(),
        .host_low_byte_enable_n(wo_lo_n), .high_byte_enable_n(wo_hi_n), .dev_ce_n(wo_ce_n), .dev_oe_n(),
        .dev_we_n(), .dev_data_in(dev_data_in), .dev_data_out(), .dev_data_oe_n());

    // ****
    // checking
    // ****
    task automatic fail(input string m);
        n_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic cmp_data(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) fail($sformatf("read data %h expected %h", g, e));
    endtask
    task automatic cmp_pin(input logic [1:0] g, input logic [1:0] e);
        checks++;
        if (g !== e) fail($sformatf("pins %b expected %b", g, e));
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // lanes not selected read back zero
    function automatic logic [15:0] exp_rd(input logic wd, input logic [12:0] a, input logic [1:0] b);
        if (!wd) return {8'h00, shd[a]};
        return {b[1] ? shd[{a[12:1], 1'b1}] : 8'h00, b[0] ? shd[{a[12:1], 1'b0}] : 8'h00};
    endfunction

    // ****
    // stimulus
    // ****
    task automatic do_req(input logic w, input logic wd, input logic [12:0] a, input logic [1:0] b,
        input logic [15:0] d);
        bls_note_t n;
        @(posedge clk);
        req_valid <= 1'b1;
        wide_mode <= wd;
        req_write <= w;
        req_addr <= a;
        req_be <= b;
        req_wdata <= d;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        cur_wide = wd;
        cur_a = a;
        cur_be = b;
        cur_noop = wd && b == 2'h0;
        n.chk = !w;
        n.d = w ? 16'h0000 : exp_rd(wd, a, b);
        notes.push_back(n);
        if (w && !wd) shd[a] = d[7:0];
        if (w && wd && b[0]) shd[{a[12:1], 1'b0}] = d[7:0];
        if (w && wd && b[1]) shd[{a[12:1], 1'b1}] = d[15:8];
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == CYC_LIMIT)
        begin
            fail("timeout");
            conclude();
        end
    end
    always @(posedge clk)
    begin
        if (!sys_rst && rsp_valid === 1'b1)
        begin
            if (notes.size() == 0) fail("unexpected answer");
            else
            begin
                got = notes.pop_front();
                if (got.chk) cmp_data(rsp_rdata, got.d);
            end
        end
        if (!sys_rst && dev_ce_n === 1'b0)
        begin
            cmp_pin({1'b0, dev_bus_width_16}, {1'b0, cur_wide});
            if (cur_wide) cmp_pin({high_byte_enable_n, host_low_byte_enable_n}, ~cur_be);
            else cmp_pin({high_byte_enable_n, host_low_byte_enable_n}, {1'b1, cur_a[0]});
            cmp_pin({1'b0, cur_noop}, 2'h0);
        end
        if (!sys_rst && wo_ce_n === 1'b0 && wo_width === 1'b1)
        begin
            cmp_pin({wo_hi_n, wo_lo_n}, 2'h0);
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        {wide_mode, req_valid, req_write, cur_wide, cur_noop} = 5'h00;
        {req_addr, cur_a, req_be, cur_be, req_wdata} = 46'h0;
        {n_errors, checks, cyc} = {32'h0, 32'h0, 32'h0};
        foreach (shd[i]) shd[i] = 8'h00;
        void'($urandom(32'hd737));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        cmp_pin({dev_ce_n, dev_we_n}, 2'h3);
        cmp_pin({high_byte_enable_n, host_low_byte_enable_n}, 2'h3);
        do_req(1'b1, 1'b1, 13'h0100, 2'h3, 16'hA1B2);
        do_req(1'b0, 1'b0, 13'h0100, 2'h0, 16'h0000);
        do_req(1'b0, 1'b0, 13'h0101, 2'h0, 16'h0000);
        do_req(1'b1, 1'b1, 13'h0100, 2'h0, 16'h5A5A);
        do_req(1'b0, 1'b1, 13'h0100, 2'h0, 16'h0000);
        do_req(1'b0, 1'b1, 13'h0100, 2'h3, 16'h0000);
        repeat (60) do_req(1'($urandom_range(1, 0)), 1'($urandom_range(1, 0)), 13'($urandom_range(63, 0)),
            2'($urandom_range(3, 0)), 16'($urandom()));
        for (int k = 0; k < 100 && notes.size() > 0; k++) @(posedge clk);
        if (notes.size() > 0) fail("missing answers");
        conclude();
    end
endmodule

`default_nettype wire
